// >>> logic/pbc_top.sv
// Two-channel program break comparator
//
// Functional notes
// - Condition 00 means instruction fetch break.
// - Conditions 01/10/11 mean read/write/either.
// - Mask selection sits in control bits 5:3.
// - Request forwarded only with enable bit 0 set.
// - Fetch match flags just before execution.
// - Data match flags after instruction finishes.
// - Stack and branch-address reads count as data.
// - Interrupt controller arbitrates before handling starts.
// - Block-move match waits for move end.
// - Transfer match waits for count or disable-select.
// - Sleep-mode break skips sleep, then continues.
// - Standby or watch entry still sets flag.
// - Enabled breaks add one state in listed cases.
// - One shared request; handler reads both flags.
// - Flags clear only by read-one then write-zero.
// - Halted after reset until module stop cleared.
// - Transfer-time breaks wait for CPU bus ownership.
// - Prefetch after flow change never breaks.
// - Break valid two states after mask set.
// - Branch-adjacent fetch breaks only when executed.
// - Mask codes ignore 0,1,2,3,4,8,12,16 low bits.
// - Master select 0 CPU only, 1 both.
// - Match address in bits 23:0, upper reads zero.
`timescale 1ns/100ps
`default_nettype none
module pbc_top
  import pbc_pkg::*;
(
  input  wire logic              clk,                      // 50 MHz clock
  input  wire logic              rst,                      // Async reset
  // Module stop control
  input  wire logic              stop_wr,                  // Write stop bit
  input  wire logic              stop_wdata,               // 1 halts unit
  output logic                   module_stop,              // Stop state
  // Register writes and reads
  input  wire logic [31:0]       wdata,                    // Write data
  input  wire logic              a_addr_wr,                // Write addr A
  input  wire logic              b_addr_wr,                // Write addr B
  input  wire logic              a_ctrl_wr,                // Write ctrl A
  input  wire logic              b_ctrl_wr,                // Write ctrl B
  input  wire logic              a_ctrl_rd,                // Read ctrl A
  input  wire logic              b_ctrl_rd,                // Read ctrl B
  output logic [31:0]            channel_a_match_address,  // Addr A
  output logic [31:0]            channel_b_match_address,  // Addr B
  output pbc_ctrl_t              channel_a_break_control,  // Ctrl A
  output pbc_ctrl_t              channel_b_break_control,  // Ctrl B
  // Bus cycles and CPU progress
  input  wire pbc_bus_t          bus,                      // Bus cycle
  input  wire logic              exec_start,               // Insn begins
  input  wire logic [ADDR_W-1:0] exec_addr,                // Its address
  input  wire logic              insn_end,                 // Insn ended
  input  wire logic              blkmove_busy,             // Block move on
  input  wire logic              dtc_owns_bus,             // Transfer master
  input  wire logic              dtc_count_done,           // Count reached
  input  wire logic              dtc_transfer_irq_disable_select_xfer,           // Disable-select
  input  wire logic              cc_mask_set,              // Mask bit set
  input  wire logic              branch_onchip,            // 1-word branch
  input  wire logic              fetch_slow_case,          // Slow prior insn
  // Sleep instruction
  input  wire logic              sleep_req,                // Sleep executed
  input  wire logic              sleep_standby,            // Standby/watch
  input  wire logic [ADDR_W-1:0] sleep_next_addr,          // Following addr
  output logic                   sleep_enter,              // Go to low power
  output logic                   sleep_skip,               // Stay awake
  // To the interrupt controller and CPU
  output logic                   break_req,                // Shared request
  output logic                   extra_state               // Add one state
);

  //////////////////////////////////////////////////////////////////////////
  // Storage
  pbc_ctrl_t         ctrl      [NCH];  // Control registers
  logic [ADDR_W-1:0] match     [NCH];  // Match addresses
  logic [NCH-1:0]    armed;            // Flag read as one
  logic [NCH-1:0]    pend_data;        // CPU data hit awaiting end
  logic [NCH-1:0]    pend_dtc;         // Transfer hit awaiting end
  logic [1:0]        block_cnt;        // Mask-set blocking states

  pbc_ctrl_t         next_ctrl [NCH];
  logic [ADDR_W-1:0] next_match[NCH];
  logic [NCH-1:0]    next_armed;
  logic [NCH-1:0]    next_pend_data;
  logic [NCH-1:0]    next_pend_dtc;
  logic [1:0]        next_block_cnt;
  logic              next_module_stop;
  logic              next_break_req;
  logic              next_sleep_enter;
  logic              next_sleep_skip;
  logic              next_extra_state;

  // Per-channel compare results
  logic [NCH-1:0]    bus_hit;    // Bus cycle meets condition
  logic [NCH-1:0]    bus_eq;     // Bus address equals match
  logic [NCH-1:0]    exec_hit;   // Executing insn at fetch break
  logic [NCH-1:0]    sleep_hit;  // Insn after sleep at fetch break
  logic [NCH-1:0]    wr_ctrl;    // Control write per channel
  logic [NCH-1:0]    wr_addr;    // Address write per channel
  logic [NCH-1:0]    rd_ctrl;    // Control read per channel
  pbc_bus_t          exec_cyc;   // Executing insn as a fetch
  pbc_bus_t          sleep_cyc;  // Sleep follower as a fetch

  //////////////////////////////////////////////////////////////////////////
  // Comparators

  // Present executed and post-sleep addresses as CPU fetches
  always_comb begin
    exec_cyc        = '0;
    exec_cyc.valid  = exec_start;
    exec_cyc.kind   = PBC_KIND_FETCH;
    exec_cyc.addr   = exec_addr;
    sleep_cyc       = '0;
    sleep_cyc.valid = sleep_req;
    sleep_cyc.kind  = PBC_KIND_FETCH;
    sleep_cyc.addr  = sleep_next_addr;
  end

  // Same comparator for every channel and source
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    pbc_chan u_bus (
      .ctrl    (ctrl[i]),
      .match   (match[i]),
      .cyc     (bus),
      .addr_eq (bus_eq[i]),
      .hit     (bus_hit[i])
    );
    // Only instructions that really execute are compared
    pbc_chan u_exec (
      .ctrl    (ctrl[i]),
      .match   (match[i]),
      .cyc     (exec_cyc),
      .addr_eq (),
      .hit     (exec_hit[i])
    );
    pbc_chan u_sleep (
      .ctrl    (ctrl[i]),
      .match   (match[i]),
      .cyc     (sleep_cyc),
      .addr_eq (),
      .hit     (sleep_hit[i])
    );
  end

  // Channel strobes, ignored while the unit is stopped
  always_comb begin
    wr_ctrl = {b_ctrl_wr, a_ctrl_wr} & {NCH{!module_stop}};
    wr_addr = {b_addr_wr, a_addr_wr} & {NCH{!module_stop}};
    rd_ctrl = {b_ctrl_rd, a_ctrl_rd} & {NCH{!module_stop}};
  end

  //////////////////////////////////////////////////////////////////////////
  // Channel registers and flags

  // Next values for control, address, arm and pending state
  always_comb begin
    logic set;
    logic clr;
    pbc_ctrl_t wc;
    set = 1'b0;
    clr = 1'b0;
    wc  = pbc_ctrl_t'(wdata[7:0]);
    for (int i = 0; i < NCH; i++) begin
      next_ctrl[i]      = ctrl[i];
      next_match[i]     = match[i];
      next_armed[i]     = armed[i];
      next_pend_data[i] = pend_data[i];
      next_pend_dtc[i]  = pend_dtc[i];
      set = 1'b0;
      // Address write keeps only the low 24 bits
      if (wr_addr[i]) begin
        next_match[i] = wdata[ADDR_W-1:0];
      end
      // Configuration fields take the written value
      if (wr_ctrl[i]) begin
        next_ctrl[i].bus_master_select   = wc.bus_master_select;
        next_ctrl[i].address_mask_select = wc.address_mask_select;
        next_ctrl[i].condition_select    = wc.condition_select;
        next_ctrl[i].break_irq_enable    = wc.break_irq_enable;
      end
      if (!module_stop) begin
        // Data hits, stack and vector reads included, wait
        if (bus_hit[i] && bus.kind != PBC_KIND_FETCH) begin
          if (bus.transfer_controller) begin
            next_pend_dtc[i] = 1'b1;
          end else begin
            next_pend_data[i] = 1'b1;
          end
        end
        // CPU data hit flags once the instruction is over
        if (pend_data[i] && insn_end && !blkmove_busy) begin
          set = 1'b1;
          next_pend_data[i] = 1'b0;
        end
        // Transfer hit flags after count or disable-select
        if (pend_dtc[i] && (dtc_count_done || dtc_transfer_irq_disable_select_xfer)) begin
          set = 1'b1;
          next_pend_dtc[i] = 1'b0;
        end
        // Fetch hit flags as the instruction begins
        if (exec_hit[i]) begin
          set = 1'b1;
        end
        // Fetch break after sleep flags in every mode
        if (sleep_hit[i]) begin
          set = 1'b1;
        end
      end
      // Clear needs a prior read of one, then a zero write
      clr = wr_ctrl[i] && armed[i] && !wc.match_flag;
      if (rd_ctrl[i] && ctrl[i].match_flag) begin
        next_armed[i] = 1'b1;
      end else if (wr_ctrl[i]) begin
        next_armed[i] = 1'b0;
      end
      // A new match wins over a clear in the same cycle
      if (set) begin
        next_ctrl[i].match_flag = 1'b1;
      end else if (clr) begin
        next_ctrl[i].match_flag = 1'b0;
      end
    end
  end

  // Register the channel state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NCH; i++) begin
        ctrl[i]  <= pbc_ctrl_t'(CTRL_RESET);
        match[i] <= ADDR_REG_RESET[ADDR_W-1:0];
      end
      armed     <= '0;
      pend_data <= '0;
      pend_dtc  <= '0;
    end else begin
      ctrl      <= next_ctrl;
      match     <= next_match;
      armed     <= next_armed;
      pend_data <= next_pend_data;
      pend_dtc  <= next_pend_dtc;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Request, blocking, sleep and stall outputs

  // Next values for unit-wide control and outputs
  always_comb begin
    logic [NCH-1:0] fetch_ch;
    logic           any_bie;
    for (int i = 0; i < NCH; i++) begin
      fetch_ch[i] = ctrl[i].condition_select == PBC_COND_FETCH;
    end
    any_bie = ctrl[0].break_irq_enable || ctrl[1].break_irq_enable;
    next_module_stop = module_stop;
    if (stop_wr) begin
      next_module_stop = stop_wdata;
    end
    // Blocking window after a mask-setting instruction
    next_block_cnt = block_cnt;
    if (cc_mask_set) begin
      next_block_cnt = MASK_BLOCK_STATES;
    end else if (block_cnt != 2'h0) begin
      next_block_cnt = block_cnt - 2'h1;
    end
    // Shared request, held off during blocking and transfers
    next_break_req = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if (ctrl[i].match_flag && ctrl[i].break_irq_enable) begin
        next_break_req = 1'b1;
      end
    end
    if (module_stop || dtc_owns_bus || cc_mask_set
        || block_cnt != 2'h0) begin
      next_break_req = 1'b0;
    end
    // Sleep: a break skips sleep mode, never standby or watch
    next_sleep_enter = 1'b0;
    next_sleep_skip  = 1'b0;
    if (sleep_req) begin
      if (!sleep_standby && !module_stop && sleep_hit != '0) begin
        next_sleep_skip = 1'b1;
      end else begin
        next_sleep_enter = 1'b1;
      end
    end
    // One extra state for the listed cases
    next_extra_state = 1'b0;
    if (any_bie && !module_stop) begin
      if (branch_onchip) begin
        next_extra_state = 1'b1;
      end
      if (fetch_ch != '0 && fetch_slow_case) begin
        next_extra_state = 1'b1;
      end
      if ((fetch_ch & bus_eq) != '0 && bus.valid && bus.onchip
          && bus.kind != PBC_KIND_FETCH) begin
        next_extra_state = 1'b1;
      end
    end
  end

  // Register unit-wide state; unit starts halted
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      module_stop <= 1'b1;
      block_cnt   <= 2'h0;
      break_req   <= 1'b0;
      sleep_enter <= 1'b0;
      sleep_skip  <= 1'b0;
      extra_state <= 1'b0;
    end else begin
      module_stop <= next_module_stop;
      block_cnt   <= next_block_cnt;
      break_req   <= next_break_req;
      sleep_enter <= next_sleep_enter;
      sleep_skip  <= next_sleep_skip;
      extra_state <= next_extra_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register readback

  // Read images come straight from the stored registers
  always_comb begin
    channel_a_match_address = {8'h00, match[0]};
    channel_b_match_address = {8'h00, match[1]};
    channel_a_break_control = ctrl[0];
    channel_b_break_control = ctrl[1];
  end

endmodule : pbc_top
`default_nettype wire

// >>> logic/pbc_pkg.sv
// Shared types and constants for the program break comparator
package pbc_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Widths and counts
  localparam int unsigned ADDR_W = 24;   // Compared address width
  localparam int unsigned NCH    = 2;    // Break channels

  // Match address register: bits above the address read as zero
  localparam logic [31:0] ADDR_REG_RESET = 32'h0000_0000;

  // Control register field positions
  localparam int unsigned FLAG_BIT  = 7;  // Condition match flag
  localparam int unsigned BMS_BIT   = 6;  // Bus master select
  localparam int unsigned AMASK_HI  = 5;  // Address mask select, top
  localparam int unsigned AMASK_LO  = 3;  // Address mask select, bottom
  localparam int unsigned CSEL_HI   = 2;  // Condition select high
  localparam int unsigned CSEL_LO   = 1;  // Condition select low
  localparam int unsigned BIE_BIT   = 0;  // Break interrupt enable
  localparam logic [7:0]  CTRL_RESET = 8'h00;

  // Timing in states (one state per clock)
  localparam logic [1:0] MASK_BLOCK_STATES = 2'h2; // Break valid after 2
  localparam int unsigned EXTRA_STATES     = 1;    // Added branch state

  //////////////////////////////////////////////////////////////////////////
  // Condition select encodings
  typedef enum logic [1:0] {
    PBC_COND_FETCH = 2'h0,
    PBC_COND_READ  = 2'h1,
    PBC_COND_WRITE = 2'h2,
    PBC_COND_RW    = 2'h3
  } pbc_cond_t;

  // Bus cycle kinds
  typedef enum logic [1:0] {
    PBC_KIND_FETCH = 2'h0,
    PBC_KIND_READ  = 2'h1,
    PBC_KIND_WRITE = 2'h2,
    PBC_KIND_IDLE  = 2'h3
  } pbc_kind_t;

  // Control register layout
  typedef struct packed {
    logic       match_flag;           // Condition match flag
    logic       bus_master_select;    // 0: CPU only, 1: CPU or transfer
    logic [2:0] address_mask_select;  // Low bits ignored in compare
    pbc_cond_t  condition_select;     // high, low
    logic       break_irq_enable;     // Forward request when 1
  } pbc_ctrl_t;

  // One observed bus cycle
  typedef struct packed {
    logic                valid;   // Cycle present this clock
    logic                transfer_controller;     // Transfer controller is master
    logic                onchip;  // Address in on-chip ROM or RAM
    pbc_kind_t           kind;    // Fetch, read or write
    logic [ADDR_W-1:0]   addr;    // Bus address
  } pbc_bus_t;

  // Ignored-bit mask for an address mask selection
  function automatic logic [ADDR_W-1:0] pbc_mask(input logic [2:0] sel);
    logic [ADDR_W-1:0] m;
    m = '0;
    case (sel)
      3'h1:    m = 24'h000001;
      3'h2:    m = 24'h000003;
      3'h3:    m = 24'h000007;
      3'h4:    m = 24'h00000f;
      3'h5:    m = 24'h0000ff;
      3'h6:    m = 24'h000fff;
      3'h7:    m = 24'h00ffff;
      default: m = 24'h000000;
    endcase
    return m;
  endfunction : pbc_mask

endpackage : pbc_pkg

// >>> logic/pbc_chan.sv
// One address comparator of a break channel
`timescale 1ns/100ps
`default_nettype none
module pbc_chan
  import pbc_pkg::*;
(
  input  wire pbc_ctrl_t         ctrl,     // Channel control fields
  input  wire logic [ADDR_W-1:0] match,    // Channel match address
  input  wire pbc_bus_t          cyc,      // Cycle to compare
  output logic                   addr_eq,  // Unmasked address bits agree
  output logic                   hit       // Full condition match
);

  logic [ADDR_W-1:0] ign;  // Ignored low bits
  logic              kind_ok;
  logic              master_ok;

  // Address, cycle type and bus master checks
  always_comb begin
    ign     = pbc_mask(ctrl.address_mask_select);
    addr_eq = ((cyc.addr ^ match) & ~ign) == '0;
    // Only the CPU when select is 0, either master when 1
    master_ok = !cyc.transfer_controller || ctrl.bus_master_select;
    case (ctrl.condition_select)
      PBC_COND_FETCH: kind_ok = cyc.kind == PBC_KIND_FETCH;
      PBC_COND_READ:  kind_ok = cyc.kind == PBC_KIND_READ;
      PBC_COND_WRITE: kind_ok = cyc.kind == PBC_KIND_WRITE;
      default: kind_ok = (cyc.kind == PBC_KIND_READ)
                       || (cyc.kind == PBC_KIND_WRITE);
    endcase
    // Fetch breaks need the CPU as master
    if (ctrl.condition_select == PBC_COND_FETCH) begin
      master_ok = !cyc.transfer_controller;
    end
    hit = cyc.valid && addr_eq && kind_ok && master_ok;
  end

endmodule : pbc_chan
`default_nettype wire

// >>> verification/pbc_bus_model.sv
// Bus master model: issues one observed bus cycle per request
`timescale 1ns/100ps
`default_nettype none
module pbc_bus_model
  import pbc_pkg::*;
(
  input  wire logic              clk,   // System clock
  input  wire logic              go,    // Issue one cycle
  input  wire logic              transfer_controller,   // Transfer controller is master
  input  wire pbc_kind_t         kind,  // Cycle kind
  input  wire logic [ADDR_W-1:0] addr,  // Cycle address
  output pbc_bus_t               bus    // Cycle seen by the comparator
);
  //////////////////////////////////////////////////////////////////////////
  // Starts idle so the comparator never sees an unknown cycle
  initial bus = '0;
  // One valid cycle per request; stack and vector reads are plain reads
  always @(posedge clk) begin
    if (go) begin
      bus <= '{1'b1, transfer_controller, 1'b1, kind, addr};
    end else begin
      // Released bus: idle kind and a scrambled address
      bus <= '{1'b0, 1'b0, 1'b0, PBC_KIND_IDLE, ~bus.addr};
    end
  end
endmodule : pbc_bus_model
`default_nettype wire

// >>> verification/pbc_assertions.sv
// Port checker for the two-channel break comparator
`timescale 1ns/100ps
`default_nettype none
module pbc_assertions
  import pbc_pkg::*;
(
  input wire logic        clk, rst, stop_wr, stop_wdata, module_stop,
  input wire logic [31:0] wdata, channel_a_match_address,
  input wire logic [31:0] channel_b_match_address,
  input wire logic        a_addr_wr, b_addr_wr, a_ctrl_wr, b_ctrl_wr,
  input wire pbc_ctrl_t   channel_a_break_control, channel_b_break_control,
  input wire logic        dtc_owns_bus, cc_mask_set, sleep_req,
  input wire logic        sleep_enter, sleep_skip, break_req, extra_state
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Channel requests that may drive the shared line
  wire logic a_on = channel_a_break_control.match_flag &
                    channel_a_break_control.break_irq_enable;
  wire logic b_on = channel_b_break_control.match_flag &
                    channel_b_break_control.break_irq_enable;
  wire logic any_en = channel_a_break_control.break_irq_enable |
                      channel_b_break_control.break_irq_enable;
  //////////////////////////////////////////////////////////////////////////
  sequence s_quiet2;
    !break_req [*2];
  endsequence
  property p_stop_hold; !stop_wr |=> $stable(module_stop); endproperty
  property p_stop_wr; stop_wr |=> module_stop == $past(stop_wdata);
  endproperty
  property p_addr_a; a_addr_wr && !module_stop |=>
    channel_a_match_address == {8'h00, $past(wdata[23:0])}; endproperty
  property p_addr_b; b_addr_wr && !module_stop |=>
    channel_b_match_address == {8'h00, $past(wdata[23:0])}; endproperty
  property p_req_src; break_req |-> $past(a_on || b_on); endproperty
  property p_req_dtc; $past(dtc_owns_bus) |-> !break_req; endproperty
  property p_mask; cc_mask_set |=> s_quiet2; endproperty
  property p_flag_a; channel_a_break_control.match_flag && !a_ctrl_wr
    |=> channel_a_break_control.match_flag; endproperty
  property p_flag_b; channel_b_break_control.match_flag && !b_ctrl_wr
    |=> channel_b_break_control.match_flag; endproperty
  property p_sleep; sleep_req && !module_stop |=> sleep_enter ^ sleep_skip;
  endproperty
  property p_extra; extra_state |-> $past(any_en); endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop moved");
  a_stop_wr: assert property (p_stop_wr) else $error("stop write lost");
  a_addr_a: assert property (p_addr_a) else $error("addr A wrong");
  a_addr_b: assert property (p_addr_b) else $error("addr B wrong");
  a_req_src: assert property (p_req_src) else $error("stray request");
  a_req_dtc: assert property (p_req_dtc) else $error("request early");
  a_mask: assert property (p_mask) else $error("request in block");
  a_flag_a: assert property (p_flag_a) else $error("flag A dropped");
  a_flag_b: assert property (p_flag_b) else $error("flag B dropped");
  a_sleep: assert property (p_sleep) else $error("no sleep answer");
  a_extra: assert property (p_extra) else $error("stray extra state");
endmodule : pbc_assertions
bind pbc_top pbc_assertions chk_u (.clk, .rst, .stop_wr, .stop_wdata,
  .module_stop, .wdata, .channel_a_match_address, .channel_b_match_address,
  .a_addr_wr, .b_addr_wr, .a_ctrl_wr, .b_ctrl_wr, .channel_a_break_control,
  .channel_b_break_control, .dtc_owns_bus, .cc_mask_set, .sleep_req,
  .sleep_enter, .sleep_skip, .break_req, .extra_state);
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the two-channel break comparator
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pbc_pkg::*;
  logic clk, rst, stop_wr, stop_wdata, module_stop, a_addr_wr, b_addr_wr;
  logic a_ctrl_wr, b_ctrl_wr, a_ctrl_rd, b_ctrl_rd, exec_start, insn_end;
  logic blkmove_busy, dtc_owns_bus, dtc_count_done, dtc_transfer_irq_disable_select_xfer;
  logic cc_mask_set, branch_onchip, fetch_slow_case, sleep_req;
  logic sleep_standby, sleep_enter, sleep_skip, break_req, extra_state;
  logic go, m_dtc;
  logic [31:0] wdata, channel_a_match_address, channel_b_match_address;
  logic [ADDR_W-1:0] exec_addr, sleep_next_addr, m_addr;
  logic [7:0] cfg_b;
  pbc_kind_t m_kind;
  pbc_ctrl_t channel_a_break_control, channel_b_break_control;
  pbc_bus_t bus;
  int err_count = 0;
  int checks = 0;
  //////////////////////////////////////////////////////////////////////////
  pbc_bus_model bus_u (.clk, .go, .transfer_controller(m_dtc), .kind(m_kind), .addr(m_addr),
    .bus);
  pbc_top dut_u (.clk, .rst, .stop_wr, .stop_wdata, .module_stop, .wdata,
    .a_addr_wr, .b_addr_wr, .a_ctrl_wr, .b_ctrl_wr, .a_ctrl_rd, .b_ctrl_rd,
    .channel_a_match_address, .channel_b_match_address,
    .channel_a_break_control, .channel_b_break_control, .bus, .exec_start,
    .exec_addr, .insn_end, .blkmove_busy, .dtc_owns_bus, .dtc_count_done,
    .dtc_transfer_irq_disable_select_xfer, .cc_mask_set, .branch_onchip, .fetch_slow_case,
    .sleep_req, .sleep_standby, .sleep_next_addr, .sleep_enter, .sleep_skip,
    .break_req, .extra_state);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Register write: strobes {addr A, addr B, ctrl A, ctrl B}
  task automatic wr(logic [3:0] sel, logic [31:0] d);
    @(posedge clk);
    {a_addr_wr, b_addr_wr, a_ctrl_wr, b_ctrl_wr} <= sel;
    wdata <= d;
    @(posedge clk);
    {a_addr_wr, b_addr_wr, a_ctrl_wr, b_ctrl_wr} <= 4'h0;
    @(negedge clk);
  endtask : wr
  // Read both control registers, then write the given settings back
  task automatic clr(logic [3:0] sel, logic [7:0] cfg);
    @(posedge clk);
    {a_ctrl_rd, b_ctrl_rd} <= 2'h3;
    @(posedge clk);
    {a_ctrl_rd, b_ctrl_rd} <= 2'h0;
    wr(sel, {24'h0, cfg});
  endtask : clr
  task automatic fetch_chk(logic [23:0] a, logic f);
    @(posedge clk);
    exec_start <= 1'b1;
    exec_addr <= a;
    @(posedge clk);
    exec_start <= 1'b0;
    @(negedge clk);
    chk(channel_a_break_control.match_flag, f);
  endtask : fetch_chk
  // Data cycle on channel B, then instruction end, then flag and clear
  task automatic data_chk(pbc_kind_t k, logic [23:0] a, logic d, logic f);
    @(posedge clk);
    {go, m_addr, m_dtc} <= {1'b1, a, d};
    m_kind <= k;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    {insn_end, dtc_count_done} <= {1'b1, d};
    @(negedge clk);
    chk(channel_b_break_control.match_flag, 1'b0);
    @(posedge clk);
    {insn_end, dtc_count_done} <= 2'h0;
    @(negedge clk);
    chk(channel_b_break_control.match_flag, f);
    clr(4'h1, cfg_b);
  endtask : data_chk
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk(module_stop, 1'b1);
    wr(4'h8, 32'h0000_1234);
    chk(channel_a_match_address, 32'h0);
    @(posedge clk);
    {stop_wr, stop_wdata} <= 2'h2;
    @(posedge clk);
    stop_wr <= 1'b0;
    @(negedge clk);
    chk(module_stop, 1'b0);
  endtask : t_reset
  task automatic t_fetch();
    wr(4'h8, 32'hff00_1000);
    chk(channel_a_match_address, 32'h0000_1000);
    wr(4'h2, 32'h01);
    fetch_chk(24'h001002, 1'b0);
    fetch_chk(24'h001000, 1'b1);
    @(negedge clk);
    chk(break_req, 1'b1);
    wr(4'h2, 32'h01);
    chk(channel_a_break_control.match_flag, 1'b1);
    clr(4'h2, 8'h01);
    chk(channel_a_break_control.match_flag, 1'b0);
    // Mask set holds the request off
    fetch_chk(24'h001000, 1'b1);
    @(posedge clk);
    cc_mask_set <= 1'b1;
    @(posedge clk);
    cc_mask_set <= 1'b0;
    @(negedge clk);
    chk(break_req, 1'b0);
    repeat (2) @(negedge clk);
    chk(break_req, 1'b0);
    @(negedge clk);
    chk(break_req, 1'b1);
    clr(4'h2, 8'h01);
  endtask : t_fetch
  task automatic t_data();
    wr(4'h4, 32'h0000_2300);
    for (int c = 1; c < 4; c++) begin
      cfg_b = {2'h0, 3'h5, c[1:0], 1'b0};
      wr(4'h1, {24'h0, cfg_b});
      data_chk(PBC_KIND_READ, 24'h0023ab, 1'b0, c[0]);
      data_chk(PBC_KIND_WRITE, 24'h0023ab, 1'b0, c[1]);
    end
    data_chk(PBC_KIND_READ, 24'h002400, 1'b0, 1'b0);
    data_chk(PBC_KIND_READ, 24'h0023ab, 1'b1, 1'b0);
    cfg_b = 8'h6e;
    wr(4'h1, {24'h0, cfg_b});
    data_chk(PBC_KIND_READ, 24'h0023ab, 1'b1, 1'b1);
    // Block move defers the flag
    @(posedge clk);
    blkmove_busy <= 1'b1;
    data_chk(PBC_KIND_READ, 24'h0023ab, 1'b0, 1'b0);
    @(posedge clk);
    blkmove_busy <= 1'b0;
    data_chk(PBC_KIND_READ, 24'h002400, 1'b0, 1'b1);
  endtask : t_data
  task automatic t_sleep(logic standby);
    @(posedge clk);
    {sleep_req, sleep_standby, sleep_next_addr} <= {2'h2 | standby, 24'h1000};
    @(posedge clk);
    sleep_req <= 1'b0;
    @(negedge clk);
    chk({sleep_enter, sleep_skip}, {standby, ~standby});
    @(negedge clk);
    chk(channel_a_break_control.match_flag, 1'b1);
    clr(4'h2, 8'h01);
  endtask : t_sleep
  // Extra state, transfer hold-off
  task automatic t_misc();
    @(posedge clk);
    {branch_onchip, dtc_owns_bus} <= 2'h3;
    @(posedge clk);
    branch_onchip <= 1'b0;
    @(negedge clk);
    chk(extra_state, 1'b1);
    fetch_chk(24'h001000, 1'b1);
    repeat (2) @(negedge clk);
    chk(break_req, 1'b0);
    @(posedge clk);
    dtc_owns_bus <= 1'b0;
    repeat (2) @(negedge clk);
    chk(break_req, 1'b1);
    clr(4'h2, 8'h01);
  endtask : t_misc
  task automatic test_done();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, stop_wr, stop_wdata, a_addr_wr, b_addr_wr, a_ctrl_wr} = 6'h20;
    {b_ctrl_wr, a_ctrl_rd, b_ctrl_rd, exec_start, insn_end, go} = 6'h0;
    {blkmove_busy, dtc_owns_bus, dtc_count_done, dtc_transfer_irq_disable_select_xfer} = 4'h0;
    {cc_mask_set, branch_onchip, fetch_slow_case, sleep_req} = 4'h0;
    {sleep_standby, m_dtc, wdata, exec_addr, sleep_next_addr} = '0;
    {m_addr, cfg_b} = '0;
    m_kind = PBC_KIND_IDLE;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_reset();
    t_fetch();
    t_data();
    t_sleep(1'b0);
    t_sleep(1'b1);
    t_misc();
    test_done();
  end
  // Watchdog far past the few hundred cycles needed
  initial begin
    #100000;
    err_count++;
    test_done();
  end
endmodule : testbench
`default_nettype wire
